//--- rtl/vpiu_pkg.sv
package vpiu_pkg;

  // Vector table geometry: sixteen two-byte slots at the top of memory
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam logic [15:0] VEC_BASE = 16'hffe0;
  localparam logic [15:0] VEC_RESET = 16'hfffe;

  // Fixed slots for the two unmaskable sources
  localparam logic [SLOT_W-1:0] SLOT_RESET = 4'hf;
  localparam logic [SLOT_W-1:0] SLOT_TRAP = 4'he;

  // Source counts of this build
  localparam int NUM_EXT = 4;
  localparam int NUM_PERIPH = 4;
  localparam int NUM_SRC = NUM_EXT + NUM_PERIPH;

  // Stack frame size on entry
  localparam logic [2:0] FRAME_BYTES = 3'h5;
  localparam logic [2:0] FRAME_LAST = 3'h4;

  // External pin sensitivity modes
  localparam logic [1:0] EXT_LOW = 2'h0;
  localparam logic [1:0] EXT_FALL = 2'h1;
  localparam logic [1:0] EXT_RISE = 2'h2;
  localparam logic [1:0] EXT_BOTH = 2'h3;

  // Core register selected by a stack transfer
  typedef enum logic [2:0] {
    VPIU_STK_PCL,
    VPIU_STK_PCH,
    VPIU_STK_X,
    VPIU_STK_A,
    VPIU_STK_CC
  } vpiu_stk_sel_t;

  // Sequencer states
  typedef enum logic [2:0] {
    VPIU_ST_BOOT,
    VPIU_ST_IDLE,
    VPIU_ST_PUSH,
    VPIU_ST_VEC_HI,
    VPIU_ST_VEC_LO,
    VPIU_ST_LOAD,
    VPIU_ST_POP
  } vpiu_state_t;

endpackage

//--- rtl/vpiu_arb_if.sv
`timescale 1ns/1ns
// Pending slot vector out to the encoder, winning slot back
interface vpiu_arb_if;
  logic [vpiu_pkg::NUM_SLOTS-1:0] pend;
  logic win_valid;
  logic [vpiu_pkg::SLOT_W-1:0] win_slot;

  modport ctl (output pend, input win_valid, input win_slot);
  modport enc (input pend, output win_valid, output win_slot);
endinterface

//--- rtl/vpiu_prio_enc.sv
`timescale 1ns/1ns
module vpiu_prio_enc (
  vpiu_arb_if.enc arb
);

  // Highest slot index wins; later iterations override earlier ones
  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_slot = '0;
    for (int i = 0; i < vpiu_pkg::NUM_SLOTS; i++) begin
      if (arb.pend[i]) begin
        arb.win_valid = 1'b1; // R1
        arb.win_slot = vpiu_pkg::SLOT_W'(i); // R1
      end
    end
  end

endmodule

//--- rtl/vpiu_ext_detect.sv
`timescale 1ns/1ns
module vpiu_ext_detect (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic [1:0] mode,
  input wire logic ack,
  output logic req
);

  logic prev_r;
  logic seen_r;
  logic edge_r;
  logic hit;

  // Edge event for the selected mode; no edge until one sample is known
  always_comb begin
    hit = 1'b0;
    if (seen_r) begin
      case (mode)
        vpiu_pkg::EXT_FALL: hit = prev_r & ~pin;
        vpiu_pkg::EXT_RISE: hit = ~prev_r & pin;
        vpiu_pkg::EXT_BOTH: hit = prev_r ^ pin;
        default: hit = 1'b0;
      endcase
    end
  end

  // Previous pin sample
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      prev_r <= pin;
      seen_r <= 1'b1;
    end
  end

  // Edge memory: a fresh edge in the ack cycle is kept, set beats clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_r <= 1'b0;
    end else if (hit) begin
      edge_r <= 1'b1; // R11
    end else if (ack || mode == vpiu_pkg::EXT_LOW) begin
      edge_r <= 1'b0;
    end
  end

  // Low level requests directly, edges through the memory
  assign req = (mode == vpiu_pkg::EXT_LOW) ? ~pin : edge_r; // R11

endmodule

//--- rtl/vpiu_top.sv
`timescale 1ns/1ns
// What this block does
// R1 - Among simultaneous pending requests only the highest priority one is granted.
// R2 - After service, next pending request granted by priority; none is lost.
// R3 - Vector is a 16-bit handler address; core loads PC from it.
// R4 - Every source owns a fixed two-byte slot from FFE0h up to FFFEh.
// R5 - Reset fetches main program start from FFFEh and has top priority.
// R6 - Several causes of one peripheral may share one slot.
// R7 - Slot count and source-to-slot mapping are per-variant parameters.
// R8 - Global mask set blocks every maskable grant.
// R9 - Masked requests stay pending and are granted once mask clears.
// R10 - Reset and trap ignore the global mask; all others obey it.
// R11 - External pin request on low level, falling, rising or both edges.
// R12 - Timer raises request on overflow, capture or compare match.
// R13 - Entry pushes PC, X, A and CC; Y is not pushed.
// R14 - Every entry pushes exactly five stack bytes.
// R15 - After saving state, hardware sets the global mask bit.
// R16 - Return from handler pops CC, A, X, then PC.
// R17 - Arbitration and grant happen only at instruction boundaries.
// R18 - Maskable requests stay high until software clears peripheral flag. External pin edge requests here clear on their own grant instead.
module vpiu_top #(
  // Slot of each maskable source, four bits per source, ext pins first
  parameter logic [vpiu_pkg::NUM_SRC*vpiu_pkg::SLOT_W-1:0] SRC_SLOT_MAP = 32'h89ab_cdef
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instr_boundary,
  input wire logic trap_req,
  input wire logic return_from_handler,
  input wire logic global_mask,
  input wire logic [vpiu_pkg::NUM_EXT-1:0] ext_pin,
  input wire logic [2*vpiu_pkg::NUM_EXT-1:0] ext_mode,
  input wire logic [vpiu_pkg::NUM_PERIPH-1:0] periph_req,
  input wire logic [7:0] vec_rd_data,
  output logic vec_rd,
  output logic [15:0] vec_addr,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic stk_push,
  output logic stk_pop,
  output vpiu_pkg::vpiu_stk_sel_t stk_sel,
  output logic set_mask,
  output logic grant,
  output logic [vpiu_pkg::SLOT_W-1:0] grant_slot,
  output logic busy
);

  vpiu_pkg::vpiu_state_t state_r;
  vpiu_pkg::vpiu_state_t state_nxt;
  logic [2:0] cnt_r;
  logic [7:0] vec_hi_r;
  logic [vpiu_pkg::SLOT_W-1:0] slot_r;
  logic [vpiu_pkg::NUM_EXT-1:0] ext_req;
  logic [vpiu_pkg::NUM_EXT-1:0] ext_ack;
  logic [vpiu_pkg::NUM_SRC-1:0] src_req;
  logic [vpiu_pkg::NUM_SLOTS-1:0] mask_pend;
  logic take;
  logic [15:0] slot_addr;

  vpiu_arb_if arb ();

  // One detector per external pin; its edge memory clears on its own grant
  for (genvar g = 0; g < vpiu_pkg::NUM_EXT; g++) begin : g_ext
    assign ext_ack[g] = grant
      && grant_slot == SRC_SLOT_MAP[g*vpiu_pkg::SLOT_W +: vpiu_pkg::SLOT_W];
    vpiu_ext_detect u_det (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin(ext_pin[g]),
      .mode(ext_mode[2*g +: 2]),
      .ack(ext_ack[g]),
      .req(ext_req[g])
    ); // R11
  end

  // Peripheral lines are levels held by their own flags, so no latch here
  assign src_req = {periph_req, ext_req}; // R18 R12

  // Fold sources onto slots; shared slots simply OR their causes
  always_comb begin
    mask_pend = '0;
    for (int s = 0; s < vpiu_pkg::NUM_SRC; s++) begin
      if (src_req[s]) begin
        mask_pend[SRC_SLOT_MAP[s*vpiu_pkg::SLOT_W +: vpiu_pkg::SLOT_W]] = 1'b1; // R6 R7
      end
    end
  end

  // Mask gates the maskable group only; trap bypasses it
  always_comb begin
    arb.pend = global_mask ? '0 : mask_pend; // R8 R9 R10
    if (trap_req) begin
      arb.pend[vpiu_pkg::SLOT_TRAP] = 1'b1; // R10
    end
  end

  vpiu_prio_enc u_enc (
    .arb(arb)
  );

  // Arbitrate only when idle and the core sits between instructions
  assign take = state_r == vpiu_pkg::VPIU_ST_IDLE && instr_boundary
    && arb.win_valid && !return_from_handler; // R17

  // Two bytes per slot above the base
  assign slot_addr = vpiu_pkg::VEC_BASE
    + {11'h000, slot_r, 1'b0}; // R4

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      vpiu_pkg::VPIU_ST_BOOT: state_nxt = vpiu_pkg::VPIU_ST_VEC_HI; // R5
      vpiu_pkg::VPIU_ST_IDLE: begin
        if (return_from_handler && instr_boundary) begin
          state_nxt = vpiu_pkg::VPIU_ST_POP;
        end else if (take) begin
          state_nxt = vpiu_pkg::VPIU_ST_PUSH;
        end
      end
      vpiu_pkg::VPIU_ST_PUSH: begin
        if (cnt_r == vpiu_pkg::FRAME_LAST) begin
          state_nxt = vpiu_pkg::VPIU_ST_VEC_HI;
        end
      end
      vpiu_pkg::VPIU_ST_VEC_HI: state_nxt = vpiu_pkg::VPIU_ST_VEC_LO;
      vpiu_pkg::VPIU_ST_VEC_LO: state_nxt = vpiu_pkg::VPIU_ST_LOAD;
      vpiu_pkg::VPIU_ST_LOAD: state_nxt = vpiu_pkg::VPIU_ST_IDLE;
      vpiu_pkg::VPIU_ST_POP: begin
        if (cnt_r == vpiu_pkg::FRAME_LAST) begin
          state_nxt = vpiu_pkg::VPIU_ST_IDLE; // R2
        end
      end
      default: state_nxt = vpiu_pkg::VPIU_ST_IDLE;
    endcase
  end

  // State register; reset always starts with the boot vector fetch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= vpiu_pkg::VPIU_ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Stack byte counter shared by push and pop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_r == vpiu_pkg::VPIU_ST_PUSH || state_r == vpiu_pkg::VPIU_ST_POP) begin
      cnt_r <= (cnt_r == vpiu_pkg::FRAME_LAST) ? '0 : cnt_r + 3'h1; // R14
    end else begin
      cnt_r <= '0;
    end
  end

  // Winning slot is frozen at the grant; reset forces the top slot
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_r <= vpiu_pkg::SLOT_RESET; // R5
    end else if (take) begin
      slot_r <= arb.win_slot; // R1
    end
  end

  // Grant pulse and the slot it names
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant <= 1'b0;
      grant_slot <= '0;
    end else begin
      grant <= take; // R1 R17
      grant_slot <= take ? arb.win_slot : grant_slot;
    end
  end

  // Push PCL, PCH, X, A, CC on entry; pop the reverse on return. Y untouched.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stk_push <= 1'b0;
      stk_pop <= 1'b0;
      stk_sel <= vpiu_pkg::VPIU_STK_PCL;
    end else begin
      stk_push <= state_r == vpiu_pkg::VPIU_ST_PUSH; // R13 R14
      stk_pop <= state_r == vpiu_pkg::VPIU_ST_POP; // R16
      if (state_r == vpiu_pkg::VPIU_ST_PUSH) begin
        stk_sel <= vpiu_pkg::vpiu_stk_sel_t'(cnt_r); // R13
      end else if (state_r == vpiu_pkg::VPIU_ST_POP) begin
        stk_sel <= vpiu_pkg::vpiu_stk_sel_t'(vpiu_pkg::FRAME_LAST - cnt_r); // R16
      end
    end
  end

  // Mask request pulses with the last (CC) push of the frame; boot leaves it to the core
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      set_mask <= 1'b0;
    end else begin
      set_mask <= state_r == vpiu_pkg::VPIU_ST_PUSH && cnt_r == vpiu_pkg::FRAME_LAST; // R15
    end
  end

  // Vector read: high byte at the even address, data back one cycle later
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_rd <= 1'b0;
      vec_addr <= vpiu_pkg::VEC_RESET;
    end else if (state_r == vpiu_pkg::VPIU_ST_BOOT) begin
      vec_rd <= 1'b1;
      vec_addr <= vpiu_pkg::VEC_RESET; // R5
    end else if (state_r == vpiu_pkg::VPIU_ST_PUSH && cnt_r == vpiu_pkg::FRAME_LAST) begin
      vec_rd <= 1'b1;
      vec_addr <= slot_addr; // R4
    end else if (state_r == vpiu_pkg::VPIU_ST_VEC_HI) begin
      vec_rd <= 1'b1;
      vec_addr <= vec_addr | 16'h0001;
    end else begin
      vec_rd <= 1'b0;
    end
  end

  // High byte capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_hi_r <= '0;
    end else if (state_r == vpiu_pkg::VPIU_ST_VEC_LO) begin
      vec_hi_r <= vec_rd_data;
    end
  end

  // Handler address to the program counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load <= 1'b0;
      pc_value <= '0;
    end else begin
      pc_load <= state_r == vpiu_pkg::VPIU_ST_LOAD; // R3
      if (state_r == vpiu_pkg::VPIU_ST_LOAD) begin
        pc_value <= {vec_hi_r, vec_rd_data}; // R3
      end
    end
  end

  // Core must hold off instruction fetch while the sequencer works
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b1;
    end else begin
      busy <= state_nxt != vpiu_pkg::VPIU_ST_IDLE;
    end
  end

endmodule

//--- verif/vpiu_chk.sv
`timescale 1ns/1ns
// Port-level watch on the sequencer of the interrupt unit
module vpiu_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instr_boundary,
  input wire logic return_from_handler,
  input wire logic global_mask,
  input wire logic [7:0] vec_rd_data,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic stk_push,
  input wire logic stk_pop,
  input vpiu_pkg::vpiu_stk_sel_t stk_sel,
  input wire logic set_mask,
  input wire logic grant,
  input wire logic [vpiu_pkg::SLOT_W-1:0] grant_slot,
  input wire logic busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Grant is registered one edge after the taking edge, so one look back suffices
  AST_TAKE: assert property (
    grant |-> $past(instr_boundary) && !$past(return_from_handler))
    else $error("grant without a boundary");
  AST_MASK: assert property (
    grant && grant_slot != vpiu_pkg::SLOT_TRAP |-> !$past(global_mask))
    else $error("maskable grant while masked");
  // First push follows the grant pulse; mask request rides on the last push
  AST_PUSH: assert property (
    grant |-> ##1 stk_push && stk_sel == vpiu_pkg::VPIU_STK_PCL && !set_mask
    ##1 stk_push && stk_sel == vpiu_pkg::VPIU_STK_PCH
    ##1 stk_push && stk_sel == vpiu_pkg::VPIU_STK_X
    ##1 stk_push && stk_sel == vpiu_pkg::VPIU_STK_A
    ##1 stk_push && stk_sel == vpiu_pkg::VPIU_STK_CC && set_mask
    ##1 !stk_push && !set_mask)
    else $error("bad entry push frame");
  AST_VEC: assert property (
    $rose(set_mask) |-> vec_rd && vec_addr == {11'h7ff, grant_slot, 1'b0}
    ##1 vec_rd && vec_addr == {11'h7ff, grant_slot, 1'b1})
    else $error("wrong vector slot address");
  AST_PC: assert property (
    pc_load |-> pc_value == {$past(vec_rd_data, 2), $past(vec_rd_data)})
    else $error("handler address not the fetched word");
  AST_BUSY: assert property (
    grant |-> busy [*8] ##1 !busy && pc_load)
    else $error("entry sequence length wrong");
  AST_POP: assert property (
    instr_boundary && return_from_handler && !busy |-> ##2 stk_pop && stk_sel == 3'h4
    ##1 stk_pop && stk_sel == 3'h3 ##1 stk_pop && stk_sel == 3'h2
    ##1 stk_pop && stk_sel == 3'h1 ##1 stk_pop && stk_sel == 3'h0 ##1 !stk_pop)
    else $error("bad return pop order");
  AST_BOOT: assert property (
    $rose(rst_n) |-> ##1 vec_rd && vec_addr == vpiu_pkg::VEC_RESET
    ##1 vec_rd && vec_addr == (vpiu_pkg::VEC_RESET | 16'h0001) ##2 pc_load)
    else $error("reset vector fetch wrong");
endmodule

//--- verif/vpiu_mem_model.sv
`timescale 1ns/1ns
// Program memory behind the vector fetch, one cycle read latency
module vpiu_mem_model (
  input wire logic core_clk,
  input wire logic vec_rd,
  input wire logic [15:0] vec_addr,
  output logic [7:0] vec_rd_data
);
  // Idle bus toggles so a late capture never sees the last good byte
  always_ff @(posedge core_clk) begin
    if (vec_rd) begin
      vec_rd_data <= vec_addr[7:0] ^ 8'h3c;
    end else begin
      vec_rd_data <= ~vec_rd_data;
    end
  end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the vectored priority interrupt unit
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n, instr_boundary, trap_req, return_from_handler, global_mask;
  logic [3:0] ext_pin, periph_req, grant_slot;
  logic [7:0] ext_mode, vec_rd_data, pend;
  logic [15:0] vec_addr, pc_value;
  logic vec_rd, pc_load, stk_push, stk_pop, set_mask, grant, busy;
  vpiu_pkg::vpiu_stk_sel_t stk_sel;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  // Pin s owns slot 7-s, peripheral p slot 3-p, all below the trap
  vpiu_top #(.SRC_SLOT_MAP(32'h0123_4567)) i_vpiu_top (.core_clk, .rst_n, .instr_boundary,
    .trap_req, .return_from_handler, .global_mask, .ext_pin, .ext_mode, .periph_req,
    .vec_rd_data, .vec_rd, .vec_addr, .pc_load, .pc_value, .stk_push, .stk_pop, .stk_sel,
    .set_mask, .grant, .grant_slot, .busy);
  vpiu_mem_model i_vpiu_mem_model (.core_clk, .vec_rd, .vec_addr, .vec_rd_data);

  always #25 core_clk = ~core_clk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end

  function automatic logic [15:0] exp_pc(logic [15:0] a);
    return {a[7:0] ^ 8'h3c, (a[7:0] | 8'h01) ^ 8'h3c};
  endfunction

  function automatic logic [7:0] cur_pend();
    logic [7:0] p;
    for (int s = 0; s < 4; s++) begin
      p[7-s] = ~ext_pin[s];
      p[3-s] = periph_req[s];
    end
    return p;
  endfunction

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic pc_chk(input logic [15:0] a);
    int n;
    n = 0;
    #1;
    while (pc_load !== 1'b1 && n < 12) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(16'(pc_load), 16'h0001);
    chk(pc_value, exp_pc(a));
  endtask

  // One boundary, then watch the grant and pop pulses for eight cycles
  task automatic bnd(input logic trp, input logic ret, input logic eg, input logic [3:0] es);
    logic [4:0] gs;
    logic [15:0] pops;
    gs = 5'h00;
    pops = 16'h0000;
    @(posedge core_clk);
    instr_boundary <= 1'b1;
    trap_req <= trp;
    return_from_handler <= ret;
    @(posedge core_clk);
    instr_boundary <= 1'b0;
    trap_req <= 1'b0;
    return_from_handler <= 1'b0;
    repeat (8) begin
      #1;
      if (grant === 1'b1) begin
        gs = {1'b1, grant_slot};
      end
      pops = pops + 16'(stk_pop);
      @(posedge core_clk);
    end
    chk(16'(gs), eg ? {12'h001, es} : 16'h0000);
    if (eg) begin
      pc_chk({11'h7ff, es, 1'b0});
    end
    chk(pops, ret ? 16'h0005 : 16'h0000);
  endtask

  // Main sequence
  initial begin
    logic [3:0] s;
    rst_n <= 1'b0;
    instr_boundary <= 1'b0;
    trap_req <= 1'b0;
    return_from_handler <= 1'b0;
    global_mask <= 1'b0;
    ext_pin <= 4'hf;
    ext_mode <= 8'h00;
    periph_req <= 4'h0;
    void'($urandom(24103));
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    pc_chk(16'hfffe);
    $display("test reset done");
    repeat (6) begin
      @(posedge core_clk);
      ext_pin <= 4'($urandom());
      periph_req <= 4'($urandom());
      @(posedge core_clk);
      pend = cur_pend();
      while (pend != 8'h00) begin
        for (int i = 0; i < 8; i++) begin
          if (pend[i]) begin
            s = 4'(i);
          end
        end
        bnd(1'b0, 1'b0, 1'b1, s);
        @(posedge core_clk);
        if (s >= 4'h4) begin
          ext_pin[7-s] <= 1'b1;
        end else begin
          periph_req[3-s] <= 1'b0;
        end
        @(posedge core_clk);
        pend = cur_pend();
      end
    end
    $display("test priority done");
    @(posedge core_clk);
    global_mask <= 1'b1;
    periph_req <= 4'h5;
    bnd(1'b0, 1'b0, 1'b0, 4'h0);
    bnd(1'b1, 1'b0, 1'b1, 4'he);
    @(posedge core_clk);
    global_mask <= 1'b0;
    bnd(1'b0, 1'b0, 1'b1, 4'h3);
    @(posedge core_clk);
    periph_req <= 4'h4;
    bnd(1'b0, 1'b1, 1'b0, 4'h0);
    bnd(1'b0, 1'b0, 1'b1, 4'h1);
    @(posedge core_clk);
    periph_req <= 4'h0;
    $display("test mask done");
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      ext_mode[1:0] <= 2'(m);
      @(posedge core_clk);
      ext_pin[0] <= 1'b0;
      bnd(1'b0, 1'b0, 2'(m) != vpiu_pkg::EXT_RISE, 4'h7);
      @(posedge core_clk);
      ext_pin[0] <= 1'b1;
      bnd(1'b0, 1'b0, m >= 2, 4'h7);
    end
    $display("test pin modes done");
    stop_test();
  end
endmodule

bind vpiu_top vpiu_chk i_vpiu_chk (.core_clk, .rst_n, .instr_boundary, .return_from_handler,
  .global_mask, .vec_rd_data, .vec_rd, .vec_addr, .pc_load, .pc_value, .stk_push, .stk_pop,
  .stk_sel, .set_mask, .grant, .grant_slot, .busy);
